// ---- logic/sfr_bank.sv ----
// Purpose: Peripheral control register bank with pending flags and clock controls.
// Assumes: Peripherals supply one-cycle event pulses and their live state.
// Notes: Timer one counter lives here since its reload and force bits are here.
// Operation
// [R1] PWM period match sets pending bit 7 (channel a) or 6 (channel b).
// [R2] Timer one overflow sets pending bit 5.
// [R3] Timer zero overflow sets pending bit 4.
// [R4] Wake-up timer time-out sets pending bit 3.
// [R5] Falling edge on pin two or one sets pending bit 2 or 1.
// [R6] Either edge on pin zero sets pending bit 0.
// [R7] Writing zero clears a pending bit; writing one leaves it.
// [R8] Timer one bytes read live counter, writes load reload; reset zero.
// [R9] Duty is upper byte plus two low bits in the shared register.
// [R10] Shared register bits 7..4 read program counter 11..8, read-only.
// [R11] Buzzer enable bit 7, resets disabled.
// [R12] Software sets start bit; hardware clears it at conversion end.
// [R13] Fast oscillator runs while its stop bit is zero.
// [R14] System clock select: zero fast, one slow.
// [R15] Slow oscillator always runs when selected, else follows enable bit.
// [R16] Slow clock type: zero crystal, one internal RC; resets to one.
// [R17] Conversion result readable as upper byte and low nibble, read-only.
// [R18] Four-bit channel select, codes 0 to 11, resets zero.
// [R19] PWM counter clear bits hold counters at zero; reset to one.
// [R20] PWM clock source bit: zero system clock, one fast RC.
// [R21] Timer one forced to ones or zero and held while set bits high.
// [R22] Timer stop bits freeze counters while one.
// [R23] Each pending source has an enable bit in the enable register.
// [R24] Interrupt request while any pending bit and its enable are set.
`timescale 1ns/1ps
module sfr_bank
    import sfr_bank_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire logic [sfr_bank_pkg::ADDR_W-1:0] addr,
    input wire logic [sfr_bank_pkg::DATA_W-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [sfr_bank_pkg::DATA_W-1:0] rdata,
    // Peripheral events and state
    input wire sfr_bank_pkg::event_in_t events,
    input wire logic ext_pin_two_level,
    input wire logic ext_pin_one_level,
    input wire logic ext_pin_zero_level,
    input wire logic timer_one_tick,
    input wire logic conv_done,
    input wire logic [11:0] conv_result,
    input wire logic [11:0] prog_counter,
    // Controls to peripherals
    output sfr_bank_pkg::ctrl_out_t ctrl,
    output logic conv_start,
    output logic [3:0] conv_channel_select,
    output logic [9:0] pwm_a_duty,
    output logic [9:0] pwm_b_duty,
    output logic timer_one_overflow,
    output logic irq_req
);
    import sfr_bank_pkg::*;

    logic [7:0] enable_reg;
    logic [7:0] pending_reg;
    logic [7:0] pending_next;
    logic [7:0] hw_set;
    logic [15:0] t1_count_reg;
    logic [15:0] t1_reload_reg;
    logic [7:0] pwm_a_up_reg;
    logic [7:0] pwm_b_up_reg;
    logic [3:0] duty_low_reg;
    logic [7:0] clkctrl_reg;
    logic [3:0] chan_reg;
    logic [7:0] runctrl_reg;
    logic [2:0] pin_prev_reg;
    logic t1_ovf;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [4:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // Pin levels are taken as synchronous; previous sample gives the edges.
    always_ff @(posedge clk)
    begin
        if (!rstn)
            pin_prev_reg <= 3'h7;
        else
            pin_prev_reg <= {ext_pin_two_level, ext_pin_one_level, ext_pin_zero_level};
    end

    // Timer one overflows on wrap from all ones when a tick arrives.
    assign t1_ovf = timer_one_tick && !runctrl_reg[BIT_T1_HALT]
        && !runctrl_reg[BIT_T1_ONES] && !runctrl_reg[BIT_T1_ZERO]
        && (t1_count_reg == ONES16);
    assign timer_one_overflow = t1_ovf;

    always_comb
    begin
        hw_set = ZERO8;
        hw_set[BIT_PWM_A] = events.pwm_a_match; // [R1]
        hw_set[BIT_PWM_B] = events.pwm_b_match; // [R1]
        hw_set[BIT_TMR1] = events.timer_one_ovf | t1_ovf; // [R2]
        hw_set[BIT_TMR0] = events.timer_zero_ovf; // [R3]
        hw_set[BIT_WKT] = events.wakeup_timeout; // [R4]
        hw_set[BIT_EXT2] = pin_prev_reg[2] & ~ext_pin_two_level; // [R5]
        hw_set[BIT_EXT1] = pin_prev_reg[1] & ~ext_pin_one_level; // [R5]
        hw_set[BIT_EXT0] = pin_prev_reg[0] ^ ext_pin_zero_level; // [R6]
        pending_next = pending_reg;
        if (wr_stb && hit(addr, OFS_PENDING))
            pending_next = pending_reg & wdata; // [R7]
        // A new event wins over a clear in the same cycle.
        pending_next = pending_next | hw_set;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            pending_reg <= ZERO8;
        else
            pending_reg <= pending_next;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            enable_reg <= ZERO8;
        else if (wr_stb && hit(addr, OFS_ENABLE))
            enable_reg <= wdata; // [R23]
    end

    assign irq_req = |(pending_reg & enable_reg); // [R24]

    // Reload bytes are written; the counter reloads on overflow.
    always_ff @(posedge clk)
    begin
        if (!rstn)
            t1_reload_reg <= ZERO16; // [R8]
        else if (wr_stb && hit(addr, OFS_TMR1_LO))
            t1_reload_reg[7:0] <= wdata; // [R8]
        else if (wr_stb && hit(addr, OFS_TMR1_HI))
            t1_reload_reg[15:8] <= wdata; // [R8]
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            t1_count_reg <= ZERO16; // [R8]
        else if (runctrl_reg[BIT_T1_ONES])
            t1_count_reg <= ONES16; // [R21]
        else if (runctrl_reg[BIT_T1_ZERO])
            t1_count_reg <= ZERO16; // [R21]
        else if (timer_one_tick && !runctrl_reg[BIT_T1_HALT]) // [R22]
        begin
            if (t1_ovf)
                t1_count_reg <= t1_reload_reg;
            else
                t1_count_reg <= t1_count_reg + 16'h0001;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            pwm_a_up_reg <= ZERO8;
            pwm_b_up_reg <= ZERO8;
            duty_low_reg <= 4'h0;
        end
        else if (wr_stb)
        begin
            if (hit(addr, OFS_PWMA_UP))
                pwm_a_up_reg <= wdata;
            if (hit(addr, OFS_PWMB_UP))
                pwm_b_up_reg <= wdata;
            if (hit(addr, OFS_PCH_DLOW))
                duty_low_reg <= wdata[3:0]; // [R10]
        end
    end

    assign pwm_a_duty = {pwm_a_up_reg, duty_low_reg[1:0]}; // [R9]
    assign pwm_b_duty = {pwm_b_up_reg, duty_low_reg[3:2]}; // [R9]

    // Start bit: software sets, completion clears; a new start beats completion.
    always_ff @(posedge clk)
    begin
        if (!rstn)
            clkctrl_reg <= CLKCTRL_RST; // [R11] [R16]
        else if (wr_stb && hit(addr, OFS_CLKCTRL))
            clkctrl_reg <= wdata & CLKCTRL_WMASK;
        else if (conv_done)
            clkctrl_reg[BIT_CSTART] <= 1'b0; // [R12]
    end

    // Codes above eleven have no channel; such writes are ignored.
    always_ff @(posedge clk)
    begin
        if (!rstn)
            chan_reg <= 4'h0; // [R18]
        else if (wr_stb && hit(addr, OFS_CONV_LO) && wdata[3:0] <= CHAN_MAX)
            chan_reg <= wdata[3:0]; // [R18]
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            runctrl_reg <= RUNCTRL_RST; // [R19]
        else if (wr_stb && hit(addr, OFS_RUNCTRL))
            runctrl_reg <= wdata;
    end

    assign conv_start = clkctrl_reg[BIT_CSTART];
    assign conv_channel_select = chan_reg;

    always_comb
    begin
        ctrl.buzzer_on = clkctrl_reg[BIT_BUZZ]; // [R11]
        ctrl.fast_osc_run = !clkctrl_reg[BIT_FSTOP]; // [R13]
        ctrl.sys_clock_select = clkctrl_reg[BIT_SYSSEL]; // [R14]
        ctrl.slow_osc_enable = clkctrl_reg[BIT_SYSSEL] | clkctrl_reg[BIT_SLOWRUN]; // [R15]
        ctrl.slow_clock_type = clkctrl_reg[BIT_SLOWTYPE]; // [R16]
        ctrl.pwm_a_counter_clear = runctrl_reg[BIT_PWMA_CLR]; // [R19]
        ctrl.pwm_b_counter_clear = runctrl_reg[BIT_PWMB_CLR]; // [R19]
        ctrl.pwm_a_clock_select = runctrl_reg[BIT_PWMA_CKS]; // [R20]
        ctrl.pwm_b_clock_select = runctrl_reg[BIT_PWMB_CKS]; // [R20]
        ctrl.timer_one_force_ones = runctrl_reg[BIT_T1_ONES]; // [R21]
        ctrl.timer_one_force_zero = runctrl_reg[BIT_T1_ZERO]; // [R21]
        ctrl.timer_one_halt = runctrl_reg[BIT_T1_HALT]; // [R22]
        ctrl.timer_zero_halt = runctrl_reg[BIT_T0_HALT]; // [R22]
    end

    // Read data stand for one cycle after the strobe, zero otherwise.
    always_ff @(posedge clk)
    begin
        if (!rstn)
            rdata <= ZERO8;
        else if (!rd_stb)
            rdata <= ZERO8;
        else
        begin
            case (addr)
                OFS_ENABLE: rdata <= enable_reg;
                OFS_PENDING: rdata <= pending_reg;
                OFS_TMR1_LO: rdata <= t1_count_reg[7:0]; // [R8]
                OFS_TMR1_HI: rdata <= t1_count_reg[15:8]; // [R8]
                OFS_PWMA_UP: rdata <= pwm_a_up_reg;
                OFS_PCH_DLOW: rdata <= {prog_counter[11:8], duty_low_reg}; // [R10]
                OFS_PWMB_UP: rdata <= pwm_b_up_reg;
                OFS_CLKCTRL: rdata <= clkctrl_reg;
                OFS_CONV_UP: rdata <= conv_result[11:4]; // [R17]
                OFS_CONV_LO: rdata <= {conv_result[3:0], chan_reg}; // [R17]
                OFS_RUNCTRL: rdata <= runctrl_reg;
                default: rdata <= ZERO8;
            endcase
        end
    end
endmodule : sfr_bank

// ---- logic/sfr_bank_pkg.sv ----
// Purpose: Constants and carrier types for the peripheral control register bank.
// Assumes: 8-bit register port with a 5-bit address.
// Notes: Offsets are byte addresses of the core's register space.
package sfr_bank_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam logic [4:0] OFS_ENABLE = 5'h08;
    localparam logic [4:0] OFS_PENDING = 5'h09;
    localparam logic [4:0] OFS_TMR1_LO = 5'h0A;
    localparam logic [4:0] OFS_TMR1_HI = 5'h0B;
    localparam logic [4:0] OFS_PWMA_UP = 5'h0C;
    localparam logic [4:0] OFS_PCH_DLOW = 5'h0D;
    localparam logic [4:0] OFS_PWMB_UP = 5'h0E;
    localparam logic [4:0] OFS_CLKCTRL = 5'h0F;
    localparam logic [4:0] OFS_CONV_UP = 5'h10;
    localparam logic [4:0] OFS_CONV_LO = 5'h11;
    localparam logic [4:0] OFS_RUNCTRL = 5'h12;
    // Pending / enable bit positions.
    localparam int BIT_PWM_A = 7;
    localparam int BIT_PWM_B = 6;
    localparam int BIT_TMR1 = 5;
    localparam int BIT_TMR0 = 4;
    localparam int BIT_WKT = 3;
    localparam int BIT_EXT2 = 2;
    localparam int BIT_EXT1 = 1;
    localparam int BIT_EXT0 = 0;
    // Clock control bits.
    localparam int BIT_BUZZ = 7;
    localparam int BIT_CSTART = 6;
    localparam int BIT_FSTOP = 4;
    localparam int BIT_SYSSEL = 3;
    localparam int BIT_SLOWRUN = 2;
    localparam int BIT_SLOWTYPE = 0;
    localparam logic [7:0] CLKCTRL_RST = 8'h01;
    localparam logic [7:0] CLKCTRL_WMASK = 8'hDD;
    // Run control bits.
    localparam int BIT_PWMA_CLR = 7;
    localparam int BIT_PWMB_CLR = 6;
    localparam int BIT_PWMA_CKS = 5;
    localparam int BIT_PWMB_CKS = 4;
    localparam int BIT_T1_ONES = 3;
    localparam int BIT_T1_ZERO = 2;
    localparam int BIT_T1_HALT = 1;
    localparam int BIT_T0_HALT = 0;
    localparam logic [7:0] RUNCTRL_RST = 8'hC0;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [15:0] ONES16 = 16'hFFFF;
    localparam logic [3:0] CHAN_MAX = 4'hB;

    typedef struct packed {
        logic pwm_a_match;
        logic pwm_b_match;
        logic timer_one_ovf;
        logic timer_zero_ovf;
        logic wakeup_timeout;
        logic ext_pin_two;
        logic ext_pin_one;
        logic ext_pin_zero;
    } event_in_t;

    typedef struct packed {
        logic buzzer_on;
        logic fast_osc_run;
        logic sys_clock_select;
        logic slow_osc_enable;
        logic slow_clock_type;
        logic pwm_a_counter_clear;
        logic pwm_b_counter_clear;
        logic pwm_a_clock_select;
        logic pwm_b_clock_select;
        logic timer_one_force_ones;
        logic timer_one_force_zero;
        logic timer_one_halt;
        logic timer_zero_halt;
    } ctrl_out_t;
endpackage : sfr_bank_pkg

// ---- testbench/sfr_bank_sva.sv ----
// Purpose: Port-level checks for the peripheral control register bank.
// Assumes: One clock, synchronous active-low reset.
// Notes: Pending flags are internal, so the bench checks them through reads.
`timescale 1ns/1ps
module sfr_bank_sva
    import sfr_bank_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire logic [sfr_bank_pkg::ADDR_W-1:0] addr,
    input wire logic [sfr_bank_pkg::DATA_W-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [sfr_bank_pkg::DATA_W-1:0] rdata,
    // Peripheral side
    input wire logic conv_done,
    input wire logic [11:0] conv_result,
    input wire logic [11:0] prog_counter,
    input wire sfr_bank_pkg::ctrl_out_t ctrl,
    input wire logic conv_start,
    input wire logic [3:0] conv_channel_select,
    input wire logic [9:0] pwm_a_duty
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic wc;
    assign wc = wr_stb && addr == OFS_CONV_LO;
    property p_pch; rd_stb && addr == OFS_PCH_DLOW |=> rdata[7:4] == $past(prog_counter[11:8]); endproperty
    a_pch: assert property (p_pch) else $error("program counter nibble wrong");
    property p_cup; rd_stb && addr == OFS_CONV_UP |=> rdata == $past(conv_result[11:4]); endproperty
    a_cup: assert property (p_cup) else $error("result upper byte wrong");
    property p_clo; rd_stb && addr == OFS_CONV_LO |=> rdata[7:4] == $past(conv_result[3:0]); endproperty
    a_clo: assert property (p_clo) else $error("result low nibble wrong");
    property p_chok; wc && wdata[3:0] <= CHAN_MAX |=> conv_channel_select == $past(wdata[3:0]); endproperty
    a_chok: assert property (p_chok) else $error("channel not taken");
    property p_chbad; wc && wdata[3:0] > CHAN_MAX |=> $stable(conv_channel_select); endproperty
    a_chbad: assert property (p_chbad) else $error("bad channel taken");
    property p_duty; wr_stb && addr == OFS_PWMA_UP |=> pwm_a_duty[9:2] == $past(wdata); endproperty
    a_duty: assert property (p_duty) else $error("duty upper byte wrong");
    property p_clk; wr_stb && addr == OFS_CLKCTRL |=> ctrl.buzzer_on == $past(wdata[7])
        && ctrl.fast_osc_run != $past(wdata[4]); endproperty
    a_clk: assert property (p_clk) else $error("buzzer or fast clock wrong");
    property p_done; conv_done && !(wr_stb && addr == OFS_CLKCTRL) |=> !conv_start; endproperty
    a_done: assert property (p_done) else $error("start bit not cleared");
    property p_slow; wr_stb && addr == OFS_CLKCTRL |=>
        ctrl.sys_clock_select == $past(wdata[3])
        && ctrl.slow_osc_enable == ($past(wdata[3]) || $past(wdata[2]))
        && ctrl.slow_clock_type == $past(wdata[0]); endproperty
    a_slow: assert property (p_slow) else $error("slow clock stopped");
    property p_run; wr_stb && addr == OFS_RUNCTRL |=> ctrl[7:0] == $past(wdata); endproperty
    a_run: assert property (p_run) else $error("run control wrong");
    c_pend: cover property (rd_stb && addr == OFS_PENDING);
    c_done: cover property (conv_done && conv_start);
    c_chbad: cover property (wc && wdata[3:0] > CHAN_MAX);
endmodule : sfr_bank_sva
bind sfr_bank sfr_bank_sva u_sva (.*);

// ---- testbench/sfr_bank_tb.sv ----
// Purpose: Self-checking bench for the peripheral control register bank.
// Assumes: Read data stand only in the cycle after the read strobe.
// Notes: Reads queue their expected data; the monitor pops one per answer.
`timescale 1ns/1ps
module sfr_bank_tb;
    import sfr_bank_pkg::*;
    localparam logic [12:0] RST_TAB [11] = '{13'h0900, 13'h0A00, 13'h0B00, 13'h0C00,
        13'h0D70, 13'h0E00, 13'h0F01, 13'h10A5, 13'h11C0, 13'h12C0, 13'h1F00};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic rd_q = 1'b0;
    logic [7:0] rdata;
    event_in_t events = 8'h00;
    logic p2 = 1'b1;
    logic p1 = 1'b1;
    logic p0 = 1'b1;
    logic tick = 1'b0;
    logic done = 1'b0;
    logic [11:0] cres = 12'hA5C;
    logic [11:0] pc = 12'h7E3;
    ctrl_out_t ctrl;
    logic cstart;
    logic [3:0] chan;
    logic [9:0] duty_a;
    logic [9:0] duty_b;
    logic t1ovf;
    int ovf_n = 0;
    logic irq;
    logic [7:0] exp_q [$];
    logic [31:0] seed = 32'h7E1FCA0B;
    logic [7:0] r;
    logic [3:0] ch = 4'h0;
    int bad_count = 0;
    int samples_checked = 0;
    sfr_bank u_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .events(events), .ext_pin_two_level(p2),
        .ext_pin_one_level(p1), .ext_pin_zero_level(p0), .timer_one_tick(tick),
        .conv_done(done), .conv_result(cres), .prog_counter(pc), .ctrl(ctrl),
        .conv_start(cstart), .conv_channel_select(chan), .pwm_a_duty(duty_a),
        .pwm_b_duty(duty_b), .timer_one_overflow(t1ovf), .irq_req(irq));
    initial forever #5 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // A read carries its expected data in d; strobes stay up between back-to-back calls.
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= w;
        rd_stb <= !w;
        if (!w) exp_q.push_back(d);
    endtask : bus
    task automatic pulse(input logic [7:0] ev, input logic tk, input logic dn);
        @(posedge clk);
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        events <= ev;
        tick <= tk;
        done <= dn;
        @(posedge clk);
        events <= 8'h00;
        tick <= 1'b0;
        done <= 1'b0;
    endtask : pulse
    task automatic report_and_stop();
        if (bad_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    always @(posedge clk)
    begin
        if (rd_q) check(rdata, exp_q.pop_front());
        if (t1ovf) ovf_n++;
        rd_q <= rd_stb;
    end
    initial
    begin
        #50000;
        bad_count++;
        report_and_stop();
    end
    initial
    begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 11; i++) bus(0, RST_TAB[i][12:8], RST_TAB[i][7:0]);
        pulse(8'hF8, 1'b0, 1'b0);
        p2 <= 1'b0;
        p1 <= 1'b0;
        p0 <= 1'b0;
        bus(0, 5'h09, 8'hFF);
        bus(1, 5'h09, 8'h00);
        bus(0, 5'h09, 8'h00);
        p2 <= 1'b1;
        p1 <= 1'b1;
        p0 <= 1'b1;
        bus(0, 5'h09, 8'h01);
        pulse(8'hF8, 1'b0, 1'b0);
        check({7'h00, irq}, 8'h00);
        bus(1, 5'h08, 8'h10);
        pulse(8'h00, 1'b0, 1'b0);
        check({7'h00, irq}, 8'h01);
        for (int k = 0; k < 8; k++)
        begin
            bus(1, 5'h09, ~(8'h01 << k));
            bus(0, 5'h09, 8'hF9 & (8'hFF << (k + 1)));
        end
        pulse(8'h00, 1'b0, 1'b0);
        check({7'h00, irq}, 8'h00);
        bus(1, 5'h12, 8'h08);
        bus(1, 5'h0A, 8'hFE);
        bus(1, 5'h0B, 8'hFF);
        bus(0, 5'h0A, 8'hFF);
        bus(1, 5'h12, 8'h00);
        pulse(8'h00, 1'b1, 1'b0);
        bus(0, 5'h0A, 8'hFE);
        bus(0, 5'h09, 8'h20);
        bus(1, 5'h12, 8'h02);
        pulse(8'h00, 1'b1, 1'b0);
        bus(0, 5'h0A, 8'hFE);
        bus(1, 5'h12, 8'h0C);
        pulse(8'h00, 1'b0, 1'b0);
        bus(0, 5'h0B, 8'hFF);
        bus(1, 5'h12, 8'h04);
        pulse(8'h00, 1'b0, 1'b0);
        bus(0, 5'h0B, 8'h00);
        repeat (8)
        begin
            seed = xs(seed);
            r = seed[7:0];
            pc <= seed[31:20];
            cres <= seed[19:8];
            ch = (r[3:0] <= CHAN_MAX) ? r[3:0] : ch;
            bus(1, 5'h0C, r);
            bus(1, 5'h0E, ~r);
            bus(1, 5'h0D, r);
            bus(1, 5'h11, r);
            bus(1, 5'h0F, r);
            bus(1, 5'h12, r);
            bus(0, 5'h0C, r);
            bus(0, 5'h0E, ~r);
            bus(0, 5'h0D, {pc[11:8], r[3:0]});
            bus(0, 5'h11, {cres[3:0], ch});
            bus(0, 5'h0F, r & CLKCTRL_WMASK);
            bus(0, 5'h12, r);
            check(duty_a[7:0], {r[5:0], r[1:0]});
            check(duty_b[7:0], {~r[5:0], r[3:2]});
        end
        // A code above eleven must leave the last legal channel in place.
        bus(1, 5'h11, 8'h0E);
        bus(0, 5'h11, {cres[3:0], ch});
        bus(1, 5'h0F, 8'h41);
        pulse(8'h00, 1'b0, 1'b0);
        check({7'h00, cstart}, 8'h01);
        pulse(8'h00, 1'b0, 1'b1);
        bus(0, 5'h0F, 8'h01);
        pulse(8'h00, 1'b0, 1'b0);
        // The monitor already took the last read inside the pulse; one more edge passes before the overflow count check.
        @(posedge clk);
        check(8'(ovf_n), 8'h01);
        report_and_stop();
    end
endmodule : sfr_bank_tb
